//--- hw/ledc_pkg.sv
// Shared constants for the LED string boost control logic.
// Assumes a 20 MHz core clock and a configuration write port driven from a serial front end.
package ledc_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam int ENABLE_TO_FIRST_START_WAIT_US = 20;
  localparam int ENABLE_TO_FIRST_START_WAIT_CYC =
    (ENABLE_TO_FIRST_START_WAIT_US * (CORE_CLK_HZ / 1_000_000));

  // ************************************************************
  // Configuration word addresses
  // ************************************************************
  localparam logic [3:0] ADDR_BANK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FS_A = 4'h1;
  localparam logic [3:0] ADDR_FS_B = 4'h2;
  localparam logic [3:0] ADDR_LSB_A = 4'h3;
  localparam logic [3:0] ADDR_MSB_A = 4'h4;
  localparam logic [3:0] ADDR_LSB_B = 4'h5;
  localparam logic [3:0] ADDR_MSB_B = 4'h6;
  localparam logic [3:0] ADDR_SINK_MAP = 4'h7;
  localparam logic [3:0] ADDR_FB_EN = 4'h8;
  localparam logic [3:0] ADDR_BOOST_CTRL = 4'h9;
  localparam logic [3:0] ADDR_AUTO_THR = 4'hA;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BANK_CTRL_EN_A = 0;
  localparam int BANK_CTRL_EN_B = 1;
  localparam int BANK_CTRL_PWM_A = 2;
  localparam int BANK_CTRL_PWM_B = 3;
  localparam int BOOST_FREQ_SEL = 0;
  localparam int BOOST_AUTO_EN = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [1:0] BANK_EN_RST = 2'h0;
  localparam logic [1:0] PWM_SEL_RST = 2'h0;
  localparam logic [4:0] FS_RST = 5'h13;
  localparam logic [10:0] BRT_RST = 11'h000;
  localparam logic [2:0] LSB_RST = 3'h0;
  localparam logic [2:0] SINK_MAP_RST = 3'h0;
  localparam logic [2:0] FB_EN_RST = 3'h7;
  localparam logic FREQ_SEL_RST = 1'b0;
  localparam logic AUTO_EN_RST = 1'b0;
  localparam logic [7:0] AUTO_THR_RST = 8'h00;

endpackage

//--- hw/ledc_wr_cdc.sv
// Toggle handshake carrying one configuration write from the link clock to the core clock.
// Assumes the link side holds no new write while link_ready_o is low.
`timescale 1ns/1ns
module ledc_wr_cdc
  import ledc_pkg::*;
(
  // Link side
  input wire logic link_clk_i,
  input wire logic link_srst_i,
  input wire logic link_wr_i,
  input wire logic [3:0] link_addr_i,
  input wire logic [7:0] link_data_i,
  output logic link_ready_o,
  // Core side
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  output logic wr_valid_o,
  output logic [3:0] wr_addr_o,
  output logic [7:0] wr_data_o
);

  typedef struct packed {
    logic req;
    logic [3:0] addr;
    logic [7:0] data;
    logic ack_m;
    logic ack_s;
  } ledc_link_t;

  typedef struct packed {
    logic req_m;
    logic req_s;
    logic ack;
    logic valid;
    logic [3:0] addr;
    logic [7:0] data;
  } ledc_core_t;

  ledc_link_t lk_q, lk_d;
  ledc_core_t cr_q, cr_d;

  // ************************************************************
  // Link domain
  // ************************************************************
  // The word is held stable from the toggle until the ack returns, so the
  // core can sample it without its own synchroniser.
  always_comb begin
    lk_d = lk_q;
    lk_d.ack_m = cr_q.ack;
    lk_d.ack_s = lk_q.ack_m;
    if (link_wr_i && (lk_q.ack_s == lk_q.req)) begin
      lk_d.req = ~lk_q.req;
      lk_d.addr = link_addr_i;
      lk_d.data = link_data_i;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_srst_i) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign link_ready_o = (lk_q.ack_s == lk_q.req);

  // ************************************************************
  // Core domain
  // ************************************************************
  always_comb begin
    cr_d = cr_q;
    cr_d.req_m = lk_q.req;
    cr_d.req_s = cr_q.req_m;
    cr_d.valid = 1'b0;
    if (cr_q.req_s != cr_q.ack) begin
      cr_d.ack = cr_q.req_s;
      cr_d.valid = 1'b1;
      cr_d.addr = lk_q.addr;
      cr_d.data = lk_q.data;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cr_q <= '0;
    end else if (ce_i) begin
      cr_q <= cr_d;
    end
  end

  assign wr_valid_o = cr_q.valid && ce_i;
  assign wr_addr_o = cr_q.addr;
  assign wr_data_o = cr_q.data;

endmodule

//--- hw/ledc_core.sv
// Control logic of a three-string LED driver: banks, sink mapping, faults, boost frequency.
// Assumes pins arrive asynchronously and configuration writes arrive on their own link clock.
`timescale 1ns/1ns
module ledc_core
  import ledc_pkg::*;
(
  // Clocks and control
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Configuration link
  input wire logic link_clk_i,
  input wire logic link_srst_i,
  input wire logic link_wr_i,
  input wire logic [3:0] link_addr_i,
  input wire logic [7:0] link_data_i,
  output logic link_ready_o,
  // Pins and analog indications
  input wire logic hardware_enable_pin_i,
  input wire logic pwm_i,
  input wire logic temp_over_i,
  input wire logic temp_release_i,
  input wire logic [2:0] sink_short_i,
  input wire logic fault_clear_i,
  // Sink controls
  output logic [2:0] sink_on_o,
  output logic [2:0] sink_pwm_o,
  output logic [2:0][10:0] sink_code_o,
  output logic [2:0][4:0] sink_fs_o,
  output logic [2:0] feedback_en_o,
  // Boost and status
  output logic boost_en_o,
  output logic boost_freq_hi_o,
  output logic fault_short_o,
  output logic thermal_off_o
);

  typedef struct packed {
    logic en_m;
    logic en_s;
    logic pwm_m;
    logic pwm_s;
    logic hot_m;
    logic hot_s;
    logic cool_m;
    logic cool_s;
    logic [2:0] short_m;
    logic [2:0] short_s;
    logic [1:0] bank_en;
    logic [1:0] pwm_sel;
    logic [4:0] fs_a;
    logic [4:0] fs_b;
    logic [2:0] lsb_a;
    logic [2:0] lsb_b;
    logic [10:0] brt_a;
    logic [10:0] brt_b;
    logic [2:0] map;
    logic [2:0] fb_en;
    logic freq_sel;
    logic auto_en;
    logic [7:0] thr;
    logic tsd;
    logic fault;
    logic [2:0] on;
    logic [2:0] pwm;
    logic [2:0][10:0] code;
    logic [2:0][4:0] fs;
    logic boost;
    logic freq_hi;
  } ledc_state_t;

  ledc_state_t q, d;
  logic wr_valid;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;

  function automatic logic [10:0] pick_code(input logic b, input logic [10:0] a,
                                            input logic [10:0] bb);
    pick_code = b ? bb : a;
  endfunction

  function automatic logic [4:0] pick_fs(input logic b, input logic [4:0] a,
                                         input logic [4:0] bb);
    pick_fs = b ? bb : a;
  endfunction

  // ************************************************************
  // Configuration write crossing
  // ************************************************************
  ledc_wr_cdc u_wr_cdc (
    .link_clk_i(link_clk_i),
    .link_srst_i(link_srst_i),
    .link_wr_i(link_wr_i),
    .link_addr_i(link_addr_i),
    .link_data_i(link_data_i),
    .link_ready_o(link_ready_o),
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .wr_valid_o(wr_valid),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [10:0] drv;
    drv = '0;
    d = q;
    d.en_m = hardware_enable_pin_i;
    d.en_s = q.en_m;
    d.pwm_m = pwm_i;
    d.pwm_s = q.pwm_m;
    d.hot_m = temp_over_i;
    d.hot_s = q.hot_m;
    d.cool_m = temp_release_i;
    d.cool_s = q.cool_m;
    d.short_m = sink_short_i;
    d.short_s = q.short_m;
    // Latched so a brief dip below the trip point does not restart the boost.
    if (q.hot_s) begin
      d.tsd = 1'b1;
    end else if (q.cool_s) begin
      d.tsd = 1'b0;
    end
    // Set beats clear so a short seen during the clear is kept.
    if (fault_clear_i) begin
      d.fault = 1'b0;
    end
    if (|(q.short_s & q.fb_en)) begin
      d.fault = 1'b1;
    end
    if (!q.en_s) begin
      d.bank_en = BANK_EN_RST;
      d.pwm_sel = PWM_SEL_RST;
      d.fs_a = FS_RST;
      d.fs_b = FS_RST;
      d.lsb_a = LSB_RST;
      d.lsb_b = LSB_RST;
      d.brt_a = BRT_RST;
      d.brt_b = BRT_RST;
      d.map = SINK_MAP_RST;
      d.fb_en = FB_EN_RST;
      d.freq_sel = FREQ_SEL_RST;
      d.auto_en = AUTO_EN_RST;
      d.thr = AUTO_THR_RST;
      d.fault = 1'b0;
    end else if (wr_valid) begin
      unique case (wr_addr)
        ADDR_BANK_CTRL: begin
          d.bank_en = {wr_data[BANK_CTRL_EN_B], wr_data[BANK_CTRL_EN_A]};
          d.pwm_sel = {wr_data[BANK_CTRL_PWM_B], wr_data[BANK_CTRL_PWM_A]};
        end
        ADDR_FS_A: d.fs_a = wr_data[4:0];
        ADDR_FS_B: d.fs_b = wr_data[4:0];
        ADDR_LSB_A: d.lsb_a = wr_data[2:0];
        ADDR_LSB_B: d.lsb_b = wr_data[2:0];
        ADDR_MSB_A: d.brt_a = {wr_data, q.lsb_a};
        ADDR_MSB_B: d.brt_b = {wr_data, q.lsb_b};
        ADDR_SINK_MAP: d.map = wr_data[2:0];
        ADDR_FB_EN: d.fb_en = wr_data[2:0];
        ADDR_BOOST_CTRL: begin
          d.freq_sel = wr_data[BOOST_FREQ_SEL];
          d.auto_en = wr_data[BOOST_AUTO_EN];
        end
        ADDR_AUTO_THR: d.thr = wr_data;
        default: d.thr = q.thr;
      endcase
    end
    for (int i = 0; i < 3; i++) begin
      d.on[i] = q.en_s && !q.tsd && q.bank_en[q.map[i]];
      d.pwm[i] = q.pwm_sel[q.map[i]] ? q.pwm_s : 1'b1;
      d.code[i] = pick_code(q.map[i], q.brt_a, q.brt_b);
      d.fs[i] = pick_fs(q.map[i], q.fs_a, q.fs_b);
    end
    d.boost = q.en_s && !q.tsd && (|q.bank_en);
    // Bank A drives the boost whenever it is enabled; B only when A is off.
    drv = pick_code(!q.bank_en[0], q.brt_a, q.brt_b);
    if (q.auto_en) begin
      d.freq_hi = (drv[10:3] > q.thr);
    end else begin
      d.freq_hi = q.freq_sel;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign sink_on_o = q.on;
  assign sink_pwm_o = q.pwm;
  assign sink_code_o = q.code;
  assign sink_fs_o = q.fs;
  assign feedback_en_o = q.fb_en;
  assign boost_en_o = q.boost;
  assign boost_freq_hi_o = q.freq_hi;
  assign fault_short_o = q.fault;
  assign thermal_off_o = q.tsd;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_pwm_duty_one: assert property (ce_i && !q.pwm_sel[q.map[0]] |=> sink_pwm_o[0])
    else $error("Sink not pwm-assigned lost full duty.");
  a_pwm_duty_pin: assert property (ce_i && q.pwm_sel[q.map[0]]
      |=> sink_pwm_o[0] == $past(q.pwm_s))
    else $error("Pwm-assigned sink does not follow the pin.");
  a_pwm_sel_write: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_BANK_CTRL
      |=> q.pwm_sel == {$past(wr_data[BANK_CTRL_PWM_B]), $past(wr_data[BANK_CTRL_PWM_A])})
    else $error("Pwm assignment not stored.");
  a_enable_low_off: assert property (ce_i && !q.en_s |=> sink_on_o == 3'h0 && !boost_en_o)
    else $error("Outputs active while enable low.");
  a_boost_runs: assert property (ce_i && q.en_s && !q.tsd && (|q.bank_en) |=> boost_en_o)
    else $error("Boost off although enabled.");
  a_enable_low_dflt: assert property (ce_i && !q.en_s
      |=> q.fb_en == FB_EN_RST && q.brt_a == BRT_RST)
    else $error("Registers not defaulted while enable low.");
  a_thermal_trip: assert property (ce_i && q.hot_s |=> thermal_off_o)
    else $error("Over-temperature did not latch shutdown.");
  a_thermal_keeps_off: assert property (ce_i && q.tsd && !q.cool_s |=> q.tsd && !boost_en_o)
    else $error("Thermal shutdown released early.");
  a_thermal_sinks_off: assert property (ce_i && q.tsd |=> sink_on_o == 3'h0 && !boost_en_o)
    else $error("Sinks on during thermal shutdown.");
  a_thermal_release: assert property (ce_i && !q.hot_s && q.cool_s |=> !thermal_off_o)
    else $error("Thermal shutdown not released when cool.");
  a_fs_b_commit: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_FS_B
      |=> q.fs_b == $past(wr_data[4:0]))
    else $error("Full-scale write not stored.");
  a_map_commit: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_SINK_MAP
      |=> q.map == $past(wr_data[2:0]))
    else $error("Sink map write not stored.");
  a_fb_commit: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_FB_EN
      |=> feedback_en_o == $past(wr_data[2:0]))
    else $error("Feedback enable write not stored.");
  a_msb_commits: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_MSB_A
      |=> q.brt_a == {$past(wr_data), $past(q.lsb_a)})
    else $error("High byte write did not commit brightness.");
  a_lsb_holds_code: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_LSB_A
      |=> $stable(q.brt_a))
    else $error("Low bits changed current before high byte.");
  a_msb_b_commit: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_MSB_B
      |=> q.brt_b == {$past(wr_data), $past(q.lsb_b)})
    else $error("High byte write did not commit bank B brightness.");
  a_sink_follows_bank: assert property (ce_i |=> sink_code_o[1] ==
      ($past(q.map[1]) ? $past(q.brt_b) : $past(q.brt_a)))
    else $error("Sink code does not follow mapped bank.");
  a_sink_fs_follows: assert property (ce_i |=> sink_fs_o[2] ==
      ($past(q.map[2]) ? $past(q.fs_b) : $past(q.fs_a)))
    else $error("Sink full-scale does not follow mapped bank.");
  a_short_flag_set: assert property (ce_i && q.en_s && |(q.short_s & q.fb_en)
      |=> fault_short_o)
    else $error("Shorted string on fed-back sink not flagged.");
  a_fault_clear: assert property (ce_i && fault_clear_i && !(|(q.short_s & q.fb_en))
      |=> !fault_short_o)
    else $error("Fault flag not cleared.");
  a_short_flag_mask: assert property (ce_i && q.en_s && !q.fault && !(|(q.short_s & q.fb_en))
      |=> !fault_short_o)
    else $error("Flag raised by excluded sink.");
  a_freq_manual: assert property (ce_i && !q.auto_en
      |=> boost_freq_hi_o == $past(q.freq_sel))
    else $error("Manual frequency select not followed.");
  a_freq_sel_write: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_BOOST_CTRL
      |=> q.freq_sel == $past(wr_data[BOOST_FREQ_SEL]))
    else $error("Frequency select bit not stored.");
  a_auto_en_write: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_BOOST_CTRL
      |=> q.auto_en == $past(wr_data[BOOST_AUTO_EN]))
    else $error("Auto frequency enable bit not stored.");
  a_thr_commit: assert property (ce_i && q.en_s && wr_valid && wr_addr == ADDR_AUTO_THR
      |=> q.thr == $past(wr_data))
    else $error("Auto frequency threshold not stored.");
  a_freq_auto: assert property (ce_i && q.auto_en && q.bank_en[0]
      |=> boost_freq_hi_o == ($past(q.brt_a[10:3]) > $past(q.thr)))
    else $error("Auto frequency threshold compare wrong.");
  a_freq_auto_b: assert property (ce_i && q.auto_en && !q.bank_en[0]
      |=> boost_freq_hi_o == ($past(q.brt_b[10:3]) > $past(q.thr)))
    else $error("Auto frequency ignores driving bank B.");

endmodule

//--- testbench/ledc_host_model.sv
// Host model issuing configuration writes on the link port of the LED control block.
// Assumes the bench supplies the link clock and mirrors the enable pin to hw_en_i.
`timescale 1ns/1ns
module ledc_host_model
  import ledc_pkg::*;
(
  // Link side
  input wire logic link_clk_i,
  input wire logic link_ready_i,
  input wire logic hw_en_i,
  output logic link_wr_o,
  output logic [3:0] link_addr_o,
  output logic [7:0] link_data_o
);
  // ************************************************************
  // Write access
  // ************************************************************
  logic started;
  initial begin
    link_wr_o = 1'b0;
    link_addr_o = 4'h0;
    link_data_o = 8'h00;
    started = 1'b0;
  end
  always @(negedge hw_en_i) started = 1'b0;
  // Lines move only at the falling link edge, so every rising edge sees clean levels.
  task automatic write(input logic [3:0] a, input logic [7:0] d, output logic ok);
    int n;
    n = 0;
    if (!started) begin
      #(ENABLE_TO_FIRST_START_WAIT_US * 1000);
      started = 1'b1;
    end
    @(negedge link_clk_i);
    while (link_ready_i !== 1'b1 && n < 64) begin
      @(negedge link_clk_i);
      n++;
    end
    link_wr_o = 1'b1;
    link_addr_o = a;
    link_data_o = d;
    @(posedge link_clk_i);
    @(negedge link_clk_i);
    // Released lines show the inverse so a stale value is never mistaken for data.
    link_wr_o = 1'b0;
    link_addr_o = ~a;
    link_data_o = ~d;
    while (link_ready_i !== 1'b1 && n < 64) begin
      @(negedge link_clk_i);
      n++;
    end
    ok = (n < 64);
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the LED control logic, driving pins and link writes.
// Assumes the host model on the link and a 20 MHz core clock with an unrelated link clock.
`timescale 1ns/1ns
module testbench;
  import ledc_pkg::*;
  logic core_clk_i, link_clk_i, srst_i, link_wr, link_ready, en_pin, pwm_i;
  logic temp_over_i, temp_release_i, fault_clear_i, boost_en_o, freq_hi_o, fault_o, therm_o;
  logic [3:0] link_addr;
  logic [7:0] link_data;
  logic [2:0] sink_short_i, sink_on_o, sink_pwm_o, fb_en_o;
  logic [2:0][10:0] code_o;
  logic [2:0][4:0] fs_o;
  logic ce_i;
  int n_fail, tests_run;
  logic ok;

  ledc_core dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .link_clk_i(link_clk_i), .link_srst_i(srst_i), .link_wr_i(link_wr),
    .link_addr_i(link_addr), .link_data_i(link_data), .link_ready_o(link_ready),
    .hardware_enable_pin_i(en_pin), .pwm_i(pwm_i), .temp_over_i(temp_over_i),
    .temp_release_i(temp_release_i), .sink_short_i(sink_short_i),
    .fault_clear_i(fault_clear_i), .sink_on_o(sink_on_o), .sink_pwm_o(sink_pwm_o),
    .sink_code_o(code_o), .sink_fs_o(fs_o), .feedback_en_o(fb_en_o),
    .boost_en_o(boost_en_o), .boost_freq_hi_o(freq_hi_o), .fault_short_o(fault_o),
    .thermal_off_o(therm_o));
  ledc_host_model host (.link_clk_i(link_clk_i), .link_ready_i(link_ready),
    .hw_en_i(en_pin), .link_wr_o(link_wr), .link_addr_o(link_addr),
    .link_data_o(link_data));

  // ************************************************************
  // Clocks and helpers
  // ************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #13;
    forever #40 link_clk_i = ~link_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pin changes need two sync stages and a register stage, so six edges is a safe margin.
  task automatic settle();
    repeat (6) @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.write(a, d, ok);
    chk(ok, 1'b1);
    settle();
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500_000;
    n_fail++;
    complete_run();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    n_fail = 0;
    tests_run = 0;
    srst_i = 1'b1;
    ce_i = 1'b1;
    {en_pin, pwm_i, temp_over_i, fault_clear_i} = 4'h0;
    temp_release_i = 1'b1;
    sink_short_i = 3'h0;
    repeat (10) @(negedge core_clk_i);
    srst_i = 1'b0;
    settle();
    chk(fb_en_o, 16'h0007);
    chk(boost_en_o, 16'h0000);
    en_pin = 1'b1;
    settle();
    wr(ADDR_LSB_A, 8'h05);
    chk(code_o[0], 16'h0000);
    wr(ADDR_MSB_A, 8'h80);
    chk(code_o[0], 16'h0405);
    wr(ADDR_FS_A, 8'h1F);
    chk(fs_o[0], 16'h001F);
    wr(ADDR_BANK_CTRL, 8'h01);
    chk({boost_en_o, sink_on_o}, 16'h000F);
    wr(ADDR_MSB_B, 8'h22);
    wr(ADDR_SINK_MAP, 8'h02);
    wr(ADDR_BANK_CTRL, 8'h07);
    chk(code_o[1], 16'h0110);
    chk(fs_o[1], {11'h000, FS_RST});
    chk(code_o[2], 16'h0405);
    settle();
    chk(sink_pwm_o, 16'h0002);
    pwm_i = 1'b1;
    settle();
    chk(sink_pwm_o, 16'h0007);
    // With the clock enable low the pin change must not reach the sinks.
    ce_i = 1'b0;
    pwm_i = 1'b0;
    settle();
    chk(sink_pwm_o, 16'h0007);
    ce_i = 1'b1;
    settle();
    chk(sink_pwm_o, 16'h0002);
    wr(ADDR_BOOST_CTRL, 8'h01);
    chk(freq_hi_o, 16'h0001);
    wr(ADDR_BOOST_CTRL, 8'h00);
    chk(freq_hi_o, 16'h0000);
    wr(ADDR_AUTO_THR, 8'h80);
    wr(ADDR_BOOST_CTRL, 8'h09);
    chk(freq_hi_o, 16'h0000);
    wr(ADDR_AUTO_THR, 8'h7F);
    chk(freq_hi_o, 16'h0001);
    wr(ADDR_BOOST_CTRL, 8'h08);
    chk(freq_hi_o, 16'h0001);
    wr(ADDR_BANK_CTRL, 8'h02);
    chk(freq_hi_o, 16'h0000);
    wr(ADDR_FB_EN, 8'h06);
    chk(fb_en_o, 16'h0006);
    sink_short_i = 3'h1;
    settle();
    chk(fault_o, 16'h0000);
    sink_short_i = 3'h2;
    settle();
    chk(fault_o, 16'h0001);
    // The short is still in the synchroniser here, so the set wins over this clear.
    sink_short_i = 3'h0;
    fault_clear_i = 1'b1;
    @(negedge core_clk_i);
    fault_clear_i = 1'b0;
    settle();
    chk(fault_o, 16'h0001);
    fault_clear_i = 1'b1;
    @(negedge core_clk_i);
    fault_clear_i = 1'b0;
    settle();
    chk(fault_o, 16'h0000);
    temp_over_i = 1'b1;
    temp_release_i = 1'b0;
    settle();
    chk({therm_o, boost_en_o, sink_on_o}, 16'h0010);
    temp_over_i = 1'b0;
    settle();
    chk(sink_on_o, 16'h0000);
    temp_release_i = 1'b1;
    settle();
    chk({boost_en_o, sink_on_o}, 16'h000A);
    en_pin = 1'b0;
    settle();
    settle();
    chk({boost_en_o, sink_on_o, freq_hi_o}, 16'h0000);
    chk(fb_en_o, 16'h0007);
    chk(code_o[1], 16'h0000);
    chk(fs_o[0], {11'h000, FS_RST});
    complete_run();
  end
endmodule
